// ### include/bca_pkg.sv
package bca_pkg;
   // memory sizes
   localparam int RAM_DEPTH = 128;
   localparam int ROM_DEPTH = 4096;
   localparam int ROM_AW    = 12;
   // status word field positions
   localparam int F_CY  = 7;
   localparam int F_AC  = 6;
   localparam int F_BSH = 4;
   localparam int F_BSL = 3;
   localparam int F_OV  = 2;
   localparam int F_PAR = 0;
   // hardware-register addresses kept by this datapath
   localparam logic [7:0] ADR_ACC  = 8'hE0;
   localparam logic [7:0] ADR_B    = 8'hF0;
   localparam logic [7:0] ADR_STAT = 8'hD0;
   localparam logic [7:0] ADR_STK  = 8'h81;
   localparam logic [7:0] ADR_WDPL = 8'h82;
   localparam logic [7:0] ADR_WDPH = 8'h83;
   // reset and fixed values
   localparam logic [7:0]  STK_RST   = 8'h07;
   localparam logic [7:0]  STAT_RST  = 8'h00;
   localparam logic [7:0]  UNMAP_VAL = 8'h00;
   localparam logic [7:0]  ONE       = 8'h01;
   localparam logic [15:0] PC_RST    = 16'h0000;
   localparam logic [15:0] PC_STEP   = 16'h0001;
   localparam logic [3:0]  BIT_BASE  = 4'h2;
   localparam logic [3:0]  BCD_MAX   = 4'h9;
   localparam logic [8:0]  BCD_LO    = 9'h006;
   localparam logic [8:0]  BCD_HI    = 9'h060;
   // operand addressing modes
   typedef enum logic [1:0] {MD_DIR, MD_IND, MD_REG, MD_IMM} bca_mode_t;
   // datapath operations
   typedef enum logic [4:0] {
      OP_NOP, OP_FETCH, OP_JUMP, OP_LDWDP, OP_CREAD, OP_XREAD, OP_XWRITE,
      OP_MOVA, OP_MOVM, OP_ADD, OP_ADDCY, OP_SUBBR, OP_DADJ, OP_MULT,
      OP_DIVI, OP_INC, OP_DECR, OP_AND, OP_OR, OP_XOR, OP_CMPA, OP_SETB,
      OP_CLRB, OP_CPLB, OP_ANDC, OP_ORC, OP_JBIT, OP_PUSH, OP_POP
   } bca_op_t;
   // sequencer
   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_WAIT = 2'b01} bca_state_t;
endpackage

// ### design/bca_datapath.sv
`timescale 1ns/1ps
// Behaviour
// - 16-bit program counter, 4K on-chip code
// - direct reaches RAM 0-127, registers above
// - indirect reaches only RAM 0-127
// - external data read/write via data pointer
// - op class selects code, internal, external
// - bit addresses map onto data bytes
// - low 32 bytes hold four register banks
// - on/off-chip fetch take equal cycles
// - all paths and memories byte wide
// - bit set, clear, complement, carry, jump
// - decimal adjust gives two BCD digits
// - 16-bit data pointer; jumps load PC
// - two's-complement add, carry, borrow
// - add, add_with_carry_op, subtract_with_borrow_op, adjust write accumulator
// - multiply/divide split accumulator and B
// - increment/decrement any byte, wrapping
// - and/or byte or bit; xor byte only
// - byte ops to accumulator or memory, bit to carry or bit
// - two status bits pick register bank
// - stack pointer resets 07, pre-increments
module bca_datapath (
   // clock and reset
   input  wire logic               ref_clk,
   input  wire logic               rst_n,
   // command
   input  wire logic               cmd_valid,
   output logic                    cmd_ready,
   input  wire bca_pkg::bca_op_t   cmd_op,
   input  wire bca_pkg::bca_mode_t cmd_mode,
   input  wire logic               cmd_to_mem,
   input  wire logic [7:0]         cmd_addr,
   input  wire logic [7:0]         cmd_imm,
   // state view
   output logic                    done,
   output logic                    jumped,
   output logic [7:0]              acc_o,
   output logic [7:0]              b_o,
   output logic [7:0]              stat_o,
   output logic [7:0]              stk_o,
   output logic [15:0]             wdp_o,
   output logic [15:0]             pc_o,
   output logic [7:0]              fetch_o,
   // on-chip code load
   input  wire logic               rom_we,
   input  wire logic [11:0]        rom_wa,
   input  wire logic [7:0]         rom_wd,
   // external code memory
   output logic [15:0]             xc_addr,
   output logic                    xc_rd,
   input  wire logic [7:0]         xc_rdata,
   // external data memory
   output logic [15:0]             xd_addr,
   output logic                    xd_rd,
   output logic                    xd_we,
   output logic [7:0]              xd_wdata,
   input  wire logic [7:0]         xd_rdata
);
   import bca_pkg::*;

   logic [7:0]  ram [0:RAM_DEPTH-1];
   logic [7:0]  rom [0:ROM_DEPTH-1];
   logic [7:0]  acc_r, acc_nxt, b_r, b_nxt, stat_r, stat_nxt, stk_r, stk_nxt;
   logic [7:0]  fb_r, fb_nxt, xwd_r, xwd_nxt, rom_q;
   logic [15:0] wdp_r, wdp_nxt, pc_r, pc_nxt, xa_r, xa_nxt, caddr;
   logic        done_r, done_nxt, jmp_r, jmp_nxt, xrd_r, xrd_nxt, xwe_r, xwe_nxt;
   logic        xcr_r, xcr_nxt, onc_r, onc_nxt, rom_re;
   bca_state_t  st_r, st_nxt;
   bca_op_t     mop_r, mop_nxt;
   logic        go, is_bit, dir, bval, to_acc, wr_en, wr_dir, ram_we, ci, cy;
   logic [1:0]  bank;
   logic [7:0]  ea, src, pop_v, wr_ad, wr_v, ram_wd, t, bb;
   logic [6:0]  ram_wa;
   logic [8:0]  sum9;
   logic [4:0]  nib;
   logic [15:0] prod;

   assign cmd_ready = (st_r == ST_IDLE);
   assign go        = cmd_valid & cmd_ready;
   assign bank      = stat_r[F_BSH:F_BSL];

   ////////////////////////////////////////////////////////////////////////////
   // effective address and operand read
   always_comb begin
      is_bit = (cmd_op >= OP_SETB) && (cmd_op <= OP_JBIT);
      dir    = 1'b1;
      ea     = cmd_addr;
      if (is_bit) begin
         // bit space is a view onto data bytes, not storage of its own
         ea = cmd_addr[7] ? {cmd_addr[7:3], 3'b000} : {BIT_BASE, cmd_addr[6:3]};
      end else if (cmd_mode == MD_IND) begin
         // pointer bit 7 dropped: indirect wraps in RAM, never hits registers
         dir = 1'b0;
         ea  = {1'b0, ram[{2'b00, bank, 2'b00, cmd_addr[0]}][6:0]};
      end else if (cmd_mode == MD_REG) begin
         dir = 1'b0;
         ea  = {3'b000, bank, cmd_addr[2:0]};
      end
   end

   always_comb begin
      if (cmd_mode == MD_IMM && !is_bit) begin
         src = cmd_imm;
      end else if (!ea[7]) begin
         src = ram[ea[6:0]];
      end else if (!dir) begin
         src = UNMAP_VAL;
      end else if (ea == ADR_ACC) begin
         src = acc_r;
      end else if (ea == ADR_B) begin
         src = b_r;
      end else if (ea == ADR_STAT) begin
         src = stat_r;
      end else if (ea == ADR_STK) begin
         src = stk_r;
      end else if (ea == ADR_WDPL) begin
         src = wdp_r[7:0];
      end else if (ea == ADR_WDPH) begin
         src = wdp_r[15:8];
      end else begin
         src = UNMAP_VAL;
      end
      // popping from above RAM returns nothing meaningful
      pop_v = stk_r[7] ? UNMAP_VAL : ram[stk_r[6:0]];
      bval  = src[cmd_addr[2:0]];
   end

   ////////////////////////////////////////////////////////////////////////////
   // operation sequencing
   always_comb begin
      acc_nxt = acc_r;   b_nxt   = b_r;    stat_nxt = stat_r;  stk_nxt = stk_r;
      wdp_nxt = wdp_r;   pc_nxt  = pc_r;   fb_nxt   = fb_r;    xa_nxt  = xa_r;
      xwd_nxt = xwd_r;   st_nxt  = st_r;   mop_nxt  = mop_r;   onc_nxt = onc_r;
      done_nxt = 1'b0;   jmp_nxt = 1'b0;   xrd_nxt  = 1'b0;    xwe_nxt = 1'b0;
      xcr_nxt  = 1'b0;   rom_re  = 1'b0;   caddr    = pc_r;
      wr_en = 1'b0;  wr_dir = dir;  wr_ad = ea;  wr_v = acc_r;
      ram_we = 1'b0; ram_wa = '0;   ram_wd = acc_r;
      to_acc = !cmd_to_mem || (cmd_mode == MD_IMM);
      ci = 1'b0; cy = stat_r[F_CY]; t = acc_r; bb = src;
      sum9 = '0; nib = '0; prod = '0;
      if (st_r == ST_WAIT) begin
         st_nxt   = ST_IDLE;
         done_nxt = 1'b1;
         // both code regions answer in the same cycle
         t = onc_r ? rom_q : xc_rdata;
         if (mop_r == OP_FETCH) begin
            fb_nxt = t;
         end else if (mop_r == OP_CREAD) begin
            acc_nxt = t;
         end else begin
            acc_nxt = xd_rdata;
         end
      end else if (go) begin
         done_nxt = 1'b1;
         case (cmd_op)
            OP_FETCH, OP_CREAD: begin
               done_nxt = 1'b0;
               st_nxt   = ST_WAIT;
               mop_nxt  = cmd_op;
               caddr    = (cmd_op == OP_FETCH) ? pc_r : wdp_r + {8'h00, acc_r};
               if (cmd_op == OP_FETCH) pc_nxt = pc_r + PC_STEP;
               xa_nxt   = caddr;
               onc_nxt  = (caddr[15:ROM_AW] == '0);
               rom_re   = 1'b1;
               xcr_nxt  = !onc_nxt;
            end
            OP_JUMP:   begin pc_nxt = {cmd_addr, cmd_imm}; jmp_nxt = 1'b1; end
            OP_LDWDP:  wdp_nxt = {cmd_addr, cmd_imm};
            OP_XREAD: begin
               done_nxt = 1'b0;
               st_nxt   = ST_WAIT;
               mop_nxt  = cmd_op;
               xa_nxt   = wdp_r;
               xrd_nxt  = 1'b1;
            end
            OP_XWRITE: begin xa_nxt = wdp_r; xwd_nxt = acc_r; xwe_nxt = 1'b1; end
            OP_MOVA:   acc_nxt = src;
            OP_MOVM:   wr_en = (cmd_mode != MD_IMM);
            OP_ADD, OP_ADDCY: begin
               ci   = (cmd_op == OP_ADDCY) & stat_r[F_CY];
               sum9 = {1'b0, acc_r} + {1'b0, src} + {8'h00, ci};
               nib  = {1'b0, acc_r[3:0]} + {1'b0, src[3:0]} + {4'h0, ci};
               acc_nxt = sum9[7:0];
               stat_nxt[F_CY] = sum9[8];
               stat_nxt[F_AC] = nib[4];
               stat_nxt[F_OV] = (acc_r[7] == src[7]) && (sum9[7] != acc_r[7]);
            end
            OP_SUBBR: begin
               ci   = stat_r[F_CY];
               sum9 = {1'b0, acc_r} - {1'b0, src} - {8'h00, ci};
               nib  = {1'b0, acc_r[3:0]} - {1'b0, src[3:0]} - {4'h0, ci};
               acc_nxt = sum9[7:0];
               stat_nxt[F_CY] = sum9[8];
               stat_nxt[F_AC] = nib[4];
               stat_nxt[F_OV] = (acc_r[7] != src[7]) && (sum9[7] != acc_r[7]);
            end
            OP_DADJ: begin
               if (acc_r[3:0] > BCD_MAX || stat_r[F_AC]) begin
                  sum9 = {1'b0, t} + BCD_LO;
                  cy   = cy | sum9[8];
                  t    = sum9[7:0];
               end
               if (t[7:4] > BCD_MAX || cy) begin
                  sum9 = {1'b0, t} + BCD_HI;
                  cy   = cy | sum9[8];
                  t    = sum9[7:0];
               end
               acc_nxt = t;
               stat_nxt[F_CY] = cy;
            end
            OP_MULT: begin
               prod = {8'h00, acc_r} * {8'h00, b_r};
               acc_nxt = prod[7:0];
               b_nxt   = prod[15:8];
               stat_nxt[F_CY] = 1'b0;
               stat_nxt[F_OV] = |prod[15:8];
            end
            OP_DIVI: begin
               stat_nxt[F_CY] = 1'b0;
               // divide by zero leaves both operands and flags overflow
               stat_nxt[F_OV] = (b_r == 8'h00);
               if (b_r != 8'h00) begin
                  acc_nxt = acc_r / b_r;
                  b_nxt   = acc_r % b_r;
               end
            end
            OP_INC, OP_DECR: begin
               wr_v = (cmd_op == OP_INC) ? src + ONE : src - ONE;
               if (cmd_mode == MD_IMM) acc_nxt = (cmd_op == OP_INC) ? acc_r + ONE : acc_r - ONE;
               else wr_en = 1'b1;
            end
            OP_AND, OP_OR, OP_XOR: begin
               wr_v = (cmd_op == OP_AND) ? (acc_r & src) :
                      (cmd_op == OP_OR)  ? (acc_r | src) : (acc_r ^ src);
               if (to_acc) acc_nxt = wr_v;
               else wr_en = 1'b1;
            end
            OP_CMPA: acc_nxt = ~acc_r;
            OP_SETB, OP_CLRB, OP_CPLB: begin
               t[0] = (cmd_op == OP_SETB) ? 1'b1 :
                      (cmd_op == OP_CLRB) ? 1'b0 : !(cmd_to_mem ? bval : stat_r[F_CY]);
               if (!cmd_to_mem) begin
                  stat_nxt[F_CY] = t[0];
               end else begin
                  bb[cmd_addr[2:0]] = t[0];
                  wr_v  = bb;
                  wr_en = 1'b1;
               end
            end
            OP_ANDC: stat_nxt[F_CY] = stat_r[F_CY] & bval;
            OP_ORC:  stat_nxt[F_CY] = stat_r[F_CY] | bval;
            OP_JBIT: if (bval) begin
               pc_nxt  = pc_r + {{8{cmd_imm[7]}}, cmd_imm};
               jmp_nxt = 1'b1;
            end
            OP_PUSH: begin
               stk_nxt = stk_r + ONE;
               wr_ad   = stk_nxt;
               wr_dir  = 1'b0;
               wr_v    = src;
               wr_en   = 1'b1;
            end
            OP_POP: begin
               stk_nxt = stk_r - ONE;
               wr_v    = pop_v;
               wr_en   = (cmd_mode != MD_IMM);
            end
            default: ;
         endcase
      end
      // byte write: RAM, kept registers, or dropped
      if (wr_en) begin
         if (!wr_ad[7]) begin
            ram_we = 1'b1;
            ram_wa = wr_ad[6:0];
            ram_wd = wr_v;
         end else if (wr_dir) begin
            if (wr_ad == ADR_ACC) acc_nxt = wr_v;
            else if (wr_ad == ADR_B) b_nxt = wr_v;
            else if (wr_ad == ADR_STAT) stat_nxt = wr_v;
            else if (wr_ad == ADR_STK) stk_nxt = wr_v;
            else if (wr_ad == ADR_WDPL) wdp_nxt[7:0] = wr_v;
            else if (wr_ad == ADR_WDPH) wdp_nxt[15:8] = wr_v;
            // other addresses ignored
         end
      end
      stat_nxt[F_PAR] = ^acc_nxt;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_r <= 8'h00;    b_r   <= 8'h00;    stat_r <= STAT_RST; stk_r  <= STK_RST;
         wdp_r <= 16'h0000; pc_r  <= PC_RST;   fb_r   <= 8'h00;    xa_r   <= 16'h0000;
         xwd_r <= 8'h00;    st_r  <= ST_IDLE;  mop_r  <= OP_NOP;   onc_r  <= 1'b0;
         done_r <= 1'b0;    jmp_r <= 1'b0;     xrd_r  <= 1'b0;     xwe_r  <= 1'b0;
         xcr_r <= 1'b0;
      end else begin
         acc_r <= acc_nxt;  b_r   <= b_nxt;    stat_r <= stat_nxt; stk_r  <= stk_nxt;
         wdp_r <= wdp_nxt;  pc_r  <= pc_nxt;   fb_r   <= fb_nxt;   xa_r   <= xa_nxt;
         xwd_r <= xwd_nxt;  st_r  <= st_nxt;   mop_r  <= mop_nxt;  onc_r  <= onc_nxt;
         done_r <= done_nxt; jmp_r <= jmp_nxt; xrd_r  <= xrd_nxt;  xwe_r  <= xwe_nxt;
         xcr_r <= xcr_nxt;
      end
   end

   // memories hold data only, so they carry no reset
   always_ff @(posedge ref_clk) begin
      if (ram_we) ram[ram_wa] <= ram_wd;
      if (rom_we) rom[rom_wa] <= rom_wd;
      if (rom_re) rom_q <= rom[caddr[ROM_AW-1:0]];
   end

   assign done = done_r;   assign jumped = jmp_r;   assign acc_o = acc_r;
   assign b_o = b_r;       assign stat_o = stat_r;  assign stk_o = stk_r;
   assign wdp_o = wdp_r;   assign pc_o = pc_r;      assign fetch_o = fb_r;
   assign xc_addr = xa_r;  assign xc_rd = xcr_r;    assign xd_addr = xa_r;
   assign xd_rd = xrd_r;   assign xd_we = xwe_r;    assign xd_wdata = xwd_r;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence s_fetch_go;  go && cmd_op == OP_FETCH; endsequence
   sequence s_two_step;  !done ##1 done;           endsequence

   a_fetch_same_time: assert property (s_fetch_go |=> s_two_step)
      else $error("fetch did not finish in two cycles");
   a_pc_advance: assert property (s_fetch_go |=> pc_o == $past(pc_o) + PC_STEP)
      else $error("program counter did not step on fetch");
   a_xread_addr: assert property (go && cmd_op == OP_XREAD |=>
      xd_rd && xd_addr == $past(wdp_o) ##1 done && !xd_rd)
      else $error("external read address or timing wrong");
   a_ind_no_regs: assert property (go && cmd_op == OP_MOVM && cmd_mode == MD_IND |=>
      b_o == $past(b_o) && stk_o == $past(stk_o) && wdp_o == $past(wdp_o))
      else $error("indirect write reached a hardware register");
   a_push_preinc: assert property (go && cmd_op == OP_PUSH |=>
      stk_o == $past(stk_o) + ONE && (stk_o[7] || ram[stk_o[6:0]] == $past(src)))
      else $error("push did not pre-increment stack");
   a_add_acc: assert property (go && cmd_op == OP_ADD |=>
      {stat_o[F_CY], acc_o} == {1'b0, $past(acc_o)} + {1'b0, $past(src)})
      else $error("add result or carry wrong");
   a_mul_split: assert property (go && cmd_op == OP_MULT |=>
      {b_o, acc_o} == {8'h00, $past(acc_o)} * {8'h00, $past(b_o)})
      else $error("multiply product split wrong");
   a_unmap_write: assert property (go && cmd_op == OP_MOVM && cmd_mode == MD_DIR &&
      cmd_addr[7] && src == UNMAP_VAL && cmd_addr != ADR_B && cmd_addr != ADR_STAT &&
      cmd_addr != ADR_STK && cmd_addr != ADR_WDPL && cmd_addr != ADR_WDPH |=>
      acc_o == $past(acc_o) && b_o == $past(b_o) && stk_o == $past(stk_o) &&
      wdp_o == $past(wdp_o) && stat_o == $past(stat_o))
      else $error("write to unmapped address changed state");
   a_bank_write: assert property (go && cmd_op == OP_MOVM && cmd_mode == MD_REG |=>
      ram[{2'b00, $past(bank), $past(cmd_addr[2:0])}] == $past(acc_o))
      else $error("register write missed selected bank");
   a_inc_wrap: assert property (go && cmd_op == OP_INC && cmd_mode == MD_IMM &&
      acc_o == 8'hFF |=> acc_o == 8'h00)
      else $error("increment did not wrap");
endmodule

// ### tb/bca_xmem_model.sv
`timescale 1ns/1ps
// off-chip code and data memories, answering in the cycle of the strobe
module bca_xmem_model (
   // clock
   input  wire logic        ref_clk,
   // code side
   input  wire logic [15:0] xc_addr,
   input  wire logic        xc_rd,
   output logic [7:0]       xc_rdata,
   // data side
   input  wire logic [15:0] xd_addr,
   input  wire logic        xd_rd,
   input  wire logic        xd_we,
   input  wire logic [7:0]  xd_wdata,
   output logic [7:0]       xd_rdata
);
   // only the low address byte is decoded: small, but enough for the bench
   logic [7:0] dmem [256];
   logic [7:0] xc_last_r = 8'h00;
   logic [7:0] xd_last_r = 8'h00;
   logic [7:0] code_byte;
   // code contents follow a fixed pattern of the address (arbitrary choice)
   assign code_byte = xc_addr[7:0] ^ xc_addr[15:8] ^ 8'h5C;
   // a released bus shows the inverse of its last byte, so stale data never passes
   always_comb begin
      xc_rdata = xc_rd ? code_byte : ~xc_last_r;
      xd_rdata = xd_rd ? dmem[xd_addr[7:0]] : ~xd_last_r;
   end
   always_ff @(posedge ref_clk) begin
      if (xc_rd) begin
         xc_last_r <= code_byte;
      end
      if (xd_rd) begin
         xd_last_r <= dmem[xd_addr[7:0]];
      end
      if (xd_we) begin
         dmem[xd_addr[7:0]] <= xd_wdata;
      end
   end
endmodule

// ### tb/tb_byte_cpu_address_spaces_alu.sv
`timescale 1ns/1ps
module tb_byte_cpu_address_spaces_alu;
   import bca_pkg::*;
   logic            ref_clk;
   logic            rst_n;
   logic            cmd_valid, cmd_ready, cmd_to_mem, done, jumped;
   bca_op_t         cmd_op;
   bca_mode_t       cmd_mode;
   logic [7:0]      cmd_addr, cmd_imm, acc_o, b_o, stat_o, stk_o, fetch_o;
   logic [15:0]     wdp_o, pc_o, xc_addr, xd_addr;
   logic            rom_we, xc_rd, xd_rd, xd_we;
   logic [11:0]     rom_wa;
   logic [7:0]      rom_wd, xc_rdata, xd_wdata, xd_rdata;
   int              errors, checked, lat, xc_cnt, xd_cnt;
   ////////////////////////////////////////////////////////////
   bca_datapath bca_datapath_inst (.ref_clk(ref_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_mode(cmd_mode), .cmd_to_mem(cmd_to_mem),
      .cmd_addr(cmd_addr), .cmd_imm(cmd_imm), .done(done), .jumped(jumped), .acc_o(acc_o),
      .b_o(b_o), .stat_o(stat_o), .stk_o(stk_o), .wdp_o(wdp_o), .pc_o(pc_o),
      .fetch_o(fetch_o), .rom_we(rom_we), .rom_wa(rom_wa), .rom_wd(rom_wd),
      .xc_addr(xc_addr), .xc_rd(xc_rd), .xc_rdata(xc_rdata), .xd_addr(xd_addr),
      .xd_rd(xd_rd), .xd_we(xd_we), .xd_wdata(xd_wdata), .xd_rdata(xd_rdata));
   bca_xmem_model bca_xmem_model_inst (.ref_clk(ref_clk), .xc_addr(xc_addr), .xc_rd(xc_rd),
      .xc_rdata(xc_rdata), .xd_addr(xd_addr), .xd_rd(xd_rd), .xd_we(xd_we),
      .xd_wdata(xd_wdata), .xd_rdata(xd_rdata));
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      xc_cnt <= xc_cnt + int'(xc_rd === 1'b1);
      xd_cnt <= xd_cnt + int'(xd_rd === 1'b1) + int'(xd_we === 1'b1);
   end
   ////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic chk8(input logic [7:0] seen, input logic [7:0] exp);
      check({8'h00, seen}, {8'h00, exp});
   endtask
   task automatic send(input bca_op_t op, input bca_mode_t md, input logic tm,
                       input logic [7:0] a, input logic [7:0] im);
      cmd_valid <= 1'b1;
      cmd_op <= op;
      cmd_mode <= md;
      cmd_to_mem <= tm;
      cmd_addr <= a;
      cmd_imm <= im;
      @(posedge ref_clk);
   endtask
   // counts edges from the taking edge up to the done pulse, bounded;
   // done stands only one cycle, so it is looked at right after the taking edge too
   task automatic wait_done();
      lat = 1;
      #1;
      while (done !== 1'b1 && lat < 8) begin
         @(posedge ref_clk);
         #1;
         lat++;
      end
      chk8({7'h00, done}, 8'h01);
   endtask
   task automatic run(input bca_op_t op, input bca_mode_t md, input logic tm,
                      input logic [7:0] a, input logic [7:0] im);
      @(posedge ref_clk);
      send(op, md, tm, a, im);
      cmd_valid <= 1'b0;
      wait_done();
   endtask
   task automatic setacc(input logic [7:0] v);
      run(OP_MOVA, MD_IMM, 1'b0, 8'h00, v);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      setacc(v);
      run(OP_MOVM, MD_DIR, 1'b0, a, 8'h00);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      run(OP_MOVA, MD_DIR, 1'b0, a, 8'h00);
      chk8(acc_o, exp);
   endtask
   ////////////////////////////////////////////////////////////
   task automatic test_reset();
      chk8({7'h00, cmd_ready}, 8'h01);
      chk8(acc_o, 8'h00);
      chk8(stat_o, STAT_RST);
      chk8(stk_o, 8'h07);
      check(pc_o, 16'h0000);
      check(wdp_o, 16'h0000);
      $display("test reset done");
   endtask
   task automatic test_arith();
      setacc(8'h38);
      // add and adjust issued back to back
      @(posedge ref_clk);
      send(OP_ADD, MD_IMM, 1'b0, 8'h00, 8'h47);
      send(OP_DADJ, MD_IMM, 1'b0, 8'h00, 8'h00);
      cmd_valid <= 1'b0;
      wait_done();
      chk8(acc_o, 8'h85);
      run(OP_ADD, MD_IMM, 1'b0, 8'h00, 8'h90);
      chk8(acc_o, 8'h15);
      chk8({7'h00, stat_o[F_CY]}, 8'h01);
      run(OP_ADDCY, MD_IMM, 1'b0, 8'h00, 8'h01);
      chk8(acc_o, 8'h17);
      run(OP_ADD, MD_IMM, 1'b0, 8'h00, 8'hF0);
      run(OP_SUBBR, MD_IMM, 1'b0, 8'h00, 8'h02);
      chk8(acc_o, 8'h04);
      chk8({7'h00, stat_o[F_CY]}, 8'h00);
      chk8({7'h00, stat_o[F_PAR]}, 8'h01);
      $display("test arith done");
   endtask
   task automatic test_muldiv();
      wr(ADR_B, 8'h10);
      setacc(8'h20);
      run(OP_MULT, MD_IMM, 1'b0, 8'h00, 8'h00);
      chk8(acc_o, 8'h00);
      chk8(b_o, 8'h02);
      chk8({7'h00, stat_o[F_OV]}, 8'h01);
      setacc(8'h25);
      run(OP_DIVI, MD_IMM, 1'b0, 8'h00, 8'h00);
      chk8(acc_o, 8'h12);
      chk8(b_o, 8'h01);
      setacc(8'hFF);
      run(OP_INC, MD_IMM, 1'b0, 8'h00, 8'h00);
      chk8(acc_o, 8'h00);
      wr(8'h30, 8'h00);
      run(OP_DECR, MD_DIR, 1'b0, 8'h30, 8'h00);
      rd_chk(8'h30, 8'hFF);
      $display("test muldiv incdec done");
   endtask
   task automatic test_space();
      wr(ADR_STAT, 8'h10);
      chk8({6'h00, stat_o[F_BSH:F_BSL]}, 8'h02);
      setacc(8'h5A);
      run(OP_MOVM, MD_REG, 1'b0, 8'h03, 8'h00);
      rd_chk(8'h13, 8'h5A);
      setacc(8'h93);
      run(OP_MOVM, MD_REG, 1'b0, 8'h00, 8'h00);
      run(OP_MOVA, MD_IND, 1'b0, 8'h00, 8'h00);
      chk8(acc_o, 8'h5A);
      wr(ADR_STAT, 8'h00);
      wr(8'h7F, 8'h77);
      rd_chk(8'h7F, 8'h77);
      wr(8'h90, 8'h66);
      rd_chk(8'h90, UNMAP_VAL);
      rd_chk(ADR_STK, 8'h07);
      setacc(8'hC3);
      run(OP_PUSH, MD_DIR, 1'b0, ADR_ACC, 8'h00);
      chk8(stk_o, 8'h08);
      rd_chk(8'h08, 8'hC3);
      run(OP_POP, MD_DIR, 1'b0, 8'h31, 8'h00);
      chk8(stk_o, 8'h07);
      rd_chk(8'h31, 8'hC3);
      $display("test space done");
   endtask
   task automatic test_logic();
      wr(8'h40, 8'h55);
      setacc(8'hF0);
      run(OP_AND, MD_IMM, 1'b0, 8'h00, 8'h3C);
      chk8(acc_o, 8'h30);
      run(OP_OR, MD_IMM, 1'b0, 8'h00, 8'h0F);
      chk8(acc_o, 8'h3F);
      run(OP_XOR, MD_IMM, 1'b0, 8'h00, 8'hFF);
      chk8(acc_o, 8'hC0);
      run(OP_CMPA, MD_IMM, 1'b0, 8'h00, 8'h00);
      chk8(acc_o, 8'h3F);
      run(OP_AND, MD_DIR, 1'b1, 8'h40, 8'h00);
      chk8(acc_o, 8'h3F);
      rd_chk(8'h40, 8'h15);
      wr(8'h20, 8'h00);
      run(OP_SETB, MD_DIR, 1'b1, 8'h05, 8'h00);
      rd_chk(8'h20, 8'h20);
      run(OP_CLRB, MD_DIR, 1'b0, 8'h00, 8'h00);
      chk8({7'h00, stat_o[F_CY]}, 8'h00);
      run(OP_CPLB, MD_DIR, 1'b0, 8'h00, 8'h00);
      chk8({7'h00, stat_o[F_CY]}, 8'h01);
      run(OP_ANDC, MD_DIR, 1'b0, 8'h06, 8'h00);
      chk8({7'h00, stat_o[F_CY]}, 8'h00);
      run(OP_ORC, MD_DIR, 1'b0, 8'h05, 8'h00);
      chk8({7'h00, stat_o[F_CY]}, 8'h01);
      run(OP_JUMP, MD_IMM, 1'b0, 8'h12, 8'h34);
      check(pc_o, 16'h1234);
      chk8({7'h00, jumped}, 8'h01);
      run(OP_JBIT, MD_DIR, 1'b0, 8'h05, 8'hFE);
      check(pc_o, 16'h1232);
      chk8({7'h00, jumped}, 8'h01);
      run(OP_JBIT, MD_DIR, 1'b0, 8'h06, 8'h10);
      chk8({7'h00, jumped}, 8'h00);
      $display("test logic bits done");
   endtask
   task automatic test_mem();
      int base;
      @(posedge ref_clk);
      rom_we <= 1'b1;
      rom_wa <= 12'h234;
      rom_wd <= 8'hA5;
      @(posedge ref_clk);
      rom_we <= 1'b0;
      base = xc_cnt;
      run(OP_JUMP, MD_IMM, 1'b0, 8'h02, 8'h34);
      run(OP_FETCH, MD_IMM, 1'b0, 8'h00, 8'h00);
      chk8(fetch_o, 8'hA5);
      check(16'(lat), 16'h0002);
      check(pc_o, 16'h0235);
      check(16'(xc_cnt - base), 16'h0000);
      run(OP_JUMP, MD_IMM, 1'b0, 8'h20, 8'h00);
      run(OP_FETCH, MD_IMM, 1'b0, 8'h00, 8'h00);
      chk8(fetch_o, 8'h7C);
      check(16'(lat), 16'h0002);
      check(16'(xc_cnt - base), 16'h0001);
      run(OP_LDWDP, MD_IMM, 1'b0, 8'h30, 8'h00);
      check(wdp_o, 16'h3000);
      setacc(8'h05);
      run(OP_CREAD, MD_IMM, 1'b0, 8'h00, 8'h00);
      chk8(acc_o, 8'h69);
      base = xd_cnt;
      run(OP_LDWDP, MD_IMM, 1'b0, 8'h12, 8'h80);
      setacc(8'h6D);
      run(OP_XWRITE, MD_IMM, 1'b0, 8'h00, 8'h00);
      setacc(8'h00);
      run(OP_XREAD, MD_IMM, 1'b0, 8'h00, 8'h00);
      chk8(acc_o, 8'h6D);
      check(16'(xd_cnt - base), 16'h0002);
      $display("test memories done");
   endtask
   ////////////////////////////////////////////////////////////
   task automatic complete_run();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      repeat (6000) @(posedge ref_clk);
      errors++;
      complete_run();
   end
   initial begin
      errors = 0;
      checked = 0;
      xc_cnt = 0;
      xd_cnt = 0;
      rst_n = 1'b0;
      cmd_valid = 1'b0;
      cmd_op = OP_NOP;
      cmd_mode = MD_IMM;
      cmd_to_mem = 1'b0;
      cmd_addr = 8'h00;
      cmd_imm = 8'h00;
      rom_we = 1'b0;
      rom_wa = 12'h000;
      rom_wd = 8'h00;
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      #1;
      test_reset();
      test_arith();
      test_muldiv();
      test_space();
      test_logic();
      test_mem();
      complete_run();
   end
endmodule
